/* logic/wsse_defines.svh */
`ifndef WSSE_DEFINES_SVH
`define WSSE_DEFINES_SVH

// ----------------------------------------------------------------------
// Step word layout
// ----------------------------------------------------------------------
`define WSSE_OPCODE_W      8
`define WSSE_VALUE_W       16
`define WSSE_STEP_W        8
`define WSSE_MSB_HI        15
`define WSSE_MSB_LO        8
`define WSSE_LSB_HI        7
`define WSSE_LSB_LO        0

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define WSSE_OP_WAIT_ARC   8'h0B
`define WSSE_OP_WAIT_WELD  8'h0C
`define WSSE_OP_JUMP       8'h0D
`define WSSE_OP_POS_BASE   8'h0E
`define WSSE_OP_SPD_BASE   8'h12
`define WSSE_OP_TEST_BASE  8'h16
`define WSSE_AXIS_LAST     8'h03

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define WSSE_RST_STEP      8'h00
`define WSSE_RST_VALUE     16'h0000
`define WSSE_RST_AXIS      4'h0
`define WSSE_ARC_QUAL_DEF  4
`endif

/* logic/wsse_pkg.sv */
package wsse_pkg;
  typedef enum logic [1:0] {
    WSSE_ST_IDLE  = 2'b00,
    WSSE_ST_RUN   = 2'b01,
    WSSE_ST_ISSUE = 2'b10,
    WSSE_ST_FAULT = 2'b11
  } wsse_state_t;

  typedef enum logic {
    WSSE_CMD_POS = 1'b0,
    WSSE_CMD_SPD = 1'b1
  } wsse_cmd_t;
endpackage

/* logic/wsse_arc_detect.sv */
`timescale 1ns/100ps
`include "wsse_defines.svh"

module wsse_arc_detect #(
  parameter int QUAL_SAMPLES = `WSSE_ARC_QUAL_DEF
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] voltage_in,
  input  wire logic [15:0] current_in,
  input  wire logic [15:0] arc_on_voltage_threshold_in,
  input  wire logic [15:0] arc_on_current_threshold_in,
  output logic             arc_present_out
);
  localparam int CNT_W = $clog2(QUAL_SAMPLES + 1);

  if (QUAL_SAMPLES < 1 || QUAL_SAMPLES > 255) begin : g_bad_qual
    $error("QUAL_SAMPLES out of range");
  end

  logic [CNT_W-1:0] qual_cnt_r;
  logic [CNT_W-1:0] qual_cnt_nxt;
  logic             sample_ok;
  logic             qual_full;

  // ----------------------------------------------------------------------
  // Qualification
  // ----------------------------------------------------------------------
  // Both figures must clear their thresholds; one bad sample drops the arc
  assign sample_ok = (voltage_in >= arc_on_voltage_threshold_in) &&
                     (current_in >= arc_on_current_threshold_in);
  assign qual_full = (qual_cnt_r == CNT_W'(QUAL_SAMPLES));
  assign qual_cnt_nxt = !sample_ok ? '0 :
                        qual_full  ? qual_cnt_r :
                        qual_cnt_r + CNT_W'(1);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      qual_cnt_r <= '0;
    end else if (sample_valid_in) begin
      qual_cnt_r <= qual_cnt_nxt;
    end
  end

  assign arc_present_out = qual_full;
endmodule

/* logic/wsse_executor.sv */
`timescale 1ns/100ps
`include "wsse_defines.svh"

module wsse_executor #(
  parameter int NUM_STEPS        = 256,
  parameter int ARC_QUAL_SAMPLES = `WSSE_ARC_QUAL_DEF
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Program load port
  input  wire logic        prog_wr_en_in,
  input  wire logic [7:0]  prog_wr_step_in,
  input  wire logic [7:0]  prog_wr_opcode_in,
  input  wire logic [15:0] prog_wr_value_in,
  // Run control
  input  wire logic        run_start_in,
  input  wire logic [7:0]  run_start_step_in,
  input  wire logic        run_stop_in,
  // Arc measurement
  input  wire logic        arc_sample_valid_in,
  input  wire logic [15:0] arc_voltage_in,
  input  wire logic [15:0] arc_current_in,
  input  wire logic [15:0] arc_on_voltage_threshold_in,
  input  wire logic [15:0] arc_on_current_threshold_in,
  // Weld sequencer and axis drives
  input  wire logic        weld_cycle_done_in,
  input  wire logic [3:0]  axis_move_done_in,
  input  wire logic [3:0]  axis_cmd_ready_in,
  output logic      [3:0]  axis_pos_valid_out,
  output logic      [3:0]  axis_speed_valid_out,
  output logic      [15:0] axis_cmd_data_out,
  // Status
  output logic             run_busy_out,
  output logic             run_fault_out,
  output logic      [7:0]  step_ptr_out,
  output logic             arc_present_out
);

  // An 8-bit pointer cannot address more than 256 steps
  if (NUM_STEPS < 2 || NUM_STEPS > 256) begin : g_bad_steps
    $error("NUM_STEPS must lie in 2..256");
  end

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [7:0] step_inc(input logic [7:0] ptr);
    step_inc = ptr + 8'h01;
  endfunction

  // Nonzero low byte is a target, zero means fall through
  function automatic logic [7:0] done_target(input logic [7:0] lsb,
                                             input logic [7:0] ptr);
    done_target = (lsb != 8'h00) ? lsb : step_inc(ptr);
  endfunction

  // Returns {advance, target}; a zero high byte means wait in place
  function automatic logic [8:0] cond_step(input logic       cond,
                                           input logic [7:0] msb,
                                           input logic [7:0] lsb,
                                           input logic [7:0] ptr);
    if (cond) begin
      cond_step = {1'b1, done_target(lsb, ptr)};
    end else if (msb != 8'h00) begin
      cond_step = {1'b1, msb};
    end else begin
      cond_step = {1'b0, ptr};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Step program storage
  // ----------------------------------------------------------------------
  logic [7:0]  prog_op_r  [NUM_STEPS];
  logic [15:0] prog_val_r [NUM_STEPS];

  always_ff @(posedge clk_sys_in) begin
    if (prog_wr_en_in && (int'(prog_wr_step_in) < NUM_STEPS)) begin
      prog_op_r[prog_wr_step_in]  <= prog_wr_opcode_in;
      prog_val_r[prog_wr_step_in] <= prog_wr_value_in;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic       weld_s1_r;
  logic       weld_s2_r;
  logic [3:0] move_s1_r;
  logic [3:0] move_s2_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      weld_s1_r <= 1'b0;
      weld_s2_r <= 1'b0;
      move_s1_r <= `WSSE_RST_AXIS;
      move_s2_r <= `WSSE_RST_AXIS;
    end else begin
      weld_s1_r <= weld_cycle_done_in;
      weld_s2_r <= weld_s1_r;
      move_s1_r <= axis_move_done_in;
      move_s2_r <= move_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // Arc detection
  // ----------------------------------------------------------------------
  logic arc_present;

  wsse_arc_detect #(
    .QUAL_SAMPLES (ARC_QUAL_SAMPLES)
  ) u_arc_detect (
    .clk_sys_in                  (clk_sys_in),
    .rst_in                      (rst_in),
    .sample_valid_in             (arc_sample_valid_in),
    .voltage_in                  (arc_voltage_in),
    .current_in                  (arc_current_in),
    .arc_on_voltage_threshold_in (arc_on_voltage_threshold_in),
    .arc_on_current_threshold_in (arc_on_current_threshold_in),
    .arc_present_out             (arc_present)
  );

  // ----------------------------------------------------------------------
  // Current step decode
  // ----------------------------------------------------------------------
  wsse_pkg::wsse_state_t state_r;
  wsse_pkg::wsse_state_t state_nxt;
  wsse_pkg::wsse_cmd_t   cmd_kind_r;
  logic [7:0]            step_ptr_r;
  logic [7:0]            step_ptr_nxt;
  logic [1:0]            cmd_axis_r;
  logic [15:0]           cmd_data_r;
  logic [3:0]            move_busy_r;

  logic                  ptr_in_range;
  logic [7:0]            cur_op;
  logic [15:0]           cur_val;
  logic [7:0]            cur_msb;
  logic [7:0]            cur_lsb;
  logic [7:0]            pos_off;
  logic [7:0]            spd_off;
  logic [7:0]            test_off;
  logic                  is_arc;
  logic                  is_weld;
  logic                  is_jump;
  logic                  is_pos;
  logic                  is_spd;
  logic                  is_test;
  logic [1:0]            op_axis;
  logic [3:0]            move_done;
  logic [8:0]            arc_res;
  logic [8:0]            weld_res;
  logic [8:0]            test_res;
  logic                  cmd_accept;
  logic [3:0]            move_armed_r;
  logic [3:0]            busy_set;

  assign ptr_in_range = (int'(step_ptr_r) < NUM_STEPS);
  assign cur_op  = ptr_in_range ? prog_op_r[step_ptr_r]  : 8'h00;
  assign cur_val = ptr_in_range ? prog_val_r[step_ptr_r] : 16'h0000;
  assign cur_msb = cur_val[`WSSE_MSB_HI:`WSSE_MSB_LO];
  assign cur_lsb = cur_val[`WSSE_LSB_HI:`WSSE_LSB_LO];

  assign pos_off  = cur_op - `WSSE_OP_POS_BASE;
  assign spd_off  = cur_op - `WSSE_OP_SPD_BASE;
  assign test_off = cur_op - `WSSE_OP_TEST_BASE;

  assign is_arc  = (cur_op == `WSSE_OP_WAIT_ARC);
  assign is_weld = (cur_op == `WSSE_OP_WAIT_WELD);
  assign is_jump = (cur_op == `WSSE_OP_JUMP);
  assign is_pos  = (cur_op >= `WSSE_OP_POS_BASE) &&
                   (pos_off <= `WSSE_AXIS_LAST);
  assign is_spd  = (cur_op >= `WSSE_OP_SPD_BASE) &&
                   (spd_off <= `WSSE_AXIS_LAST);
  assign is_test = (cur_op >= `WSSE_OP_TEST_BASE) &&
                   (test_off <= `WSSE_AXIS_LAST);

  // Index 0 is axis 1 (horizontal), index 1 is axis 2 (vertical)
  assign op_axis = is_pos ? pos_off[1:0] :
                   is_spd ? spd_off[1:0] :
                   test_off[1:0];

  // Synced done can still show the previous move for a few cycles after
  // a new command; the local busy bit hides that stale level.
  assign move_done = move_s2_r & ~move_busy_r;

  assign arc_res  = cond_step(arc_present, cur_msb, cur_lsb,
                              step_ptr_r);
  assign weld_res = cond_step(weld_s2_r, cur_msb, cur_lsb,
                              step_ptr_r);
  assign test_res = cond_step(move_done[op_axis], cur_msb, cur_lsb,
                              step_ptr_r);

  assign cmd_accept = (state_r == wsse_pkg::WSSE_ST_ISSUE) &&
                      axis_cmd_ready_in[cmd_axis_r];
  assign busy_set = (cmd_accept && cmd_kind_r == wsse_pkg::WSSE_CMD_POS) ?
                    (4'h1 << cmd_axis_r) : 4'h0;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    step_ptr_nxt = step_ptr_r;
    unique case (state_r)
      wsse_pkg::WSSE_ST_IDLE,
      wsse_pkg::WSSE_ST_FAULT: begin
        if (run_start_in) begin
          state_nxt    = wsse_pkg::WSSE_ST_RUN;
          step_ptr_nxt = run_start_step_in;
        end
      end
      wsse_pkg::WSSE_ST_RUN: begin
        if (is_arc) begin
          step_ptr_nxt = arc_res[7:0];
        end else if (is_weld) begin
          step_ptr_nxt = weld_res[7:0];
        end else if (is_jump) begin
          step_ptr_nxt = cur_lsb;
        end else if (is_pos || is_spd) begin
          state_nxt = wsse_pkg::WSSE_ST_ISSUE;
        end else if (is_test) begin
          step_ptr_nxt = test_res[7:0];
        end else begin
          // Opcodes owned by other units stop the run here
          state_nxt = wsse_pkg::WSSE_ST_FAULT;
        end
      end
      wsse_pkg::WSSE_ST_ISSUE: begin
        if (cmd_accept) begin
          state_nxt    = wsse_pkg::WSSE_ST_RUN;
          step_ptr_nxt = step_inc(step_ptr_r);
        end
      end
    endcase
    if (run_stop_in) begin
      state_nxt = wsse_pkg::WSSE_ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_r    <= wsse_pkg::WSSE_ST_IDLE;
      step_ptr_r <= `WSSE_RST_STEP;
    end else begin
      state_r    <= state_nxt;
      step_ptr_r <= step_ptr_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Axis command latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_kind_r <= wsse_pkg::WSSE_CMD_POS;
      cmd_axis_r <= 2'h0;
      cmd_data_r <= `WSSE_RST_VALUE;
    end else if (state_r == wsse_pkg::WSSE_ST_RUN &&
                 (is_pos || is_spd)) begin
      cmd_kind_r <= is_pos ? wsse_pkg::WSSE_CMD_POS
                           : wsse_pkg::WSSE_CMD_SPD;
      cmd_axis_r <= op_axis;
      cmd_data_r <= cur_val;
    end
  end

  // Busy ends only on a high seen after the drive has shown low; a finish
  // of the previous move still in the synchroniser cannot end the new one.
  // New command wins over a clear in the same cycle.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      move_busy_r  <= `WSSE_RST_AXIS;
      move_armed_r <= `WSSE_RST_AXIS;
    end else begin
      move_busy_r  <= (move_busy_r & ~(move_armed_r & move_s2_r)) |
                      busy_set;
      move_armed_r <= (move_armed_r | (move_busy_r & ~move_s2_r)) &
                      ~busy_set;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic [3:0] axis_onehot;

  assign axis_onehot = (state_r == wsse_pkg::WSSE_ST_ISSUE) ?
                       (4'h1 << cmd_axis_r) : 4'h0;

  assign axis_pos_valid_out =
    (cmd_kind_r == wsse_pkg::WSSE_CMD_POS) ? axis_onehot : 4'h0;
  assign axis_speed_valid_out =
    (cmd_kind_r == wsse_pkg::WSSE_CMD_SPD) ? axis_onehot : 4'h0;
  assign axis_cmd_data_out = cmd_data_r;
  assign run_busy_out  = (state_r == wsse_pkg::WSSE_ST_RUN) ||
                         (state_r == wsse_pkg::WSSE_ST_ISSUE);
  assign run_fault_out = (state_r == wsse_pkg::WSSE_ST_FAULT);
  assign step_ptr_out  = step_ptr_r;
  assign arc_present_out = arc_present;
endmodule

/* tb/wsse_asserts.sv */
`timescale 1ns/100ps
module wsse_asserts (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        run_start_in,
  input wire logic [7:0]  run_start_step_in,
  input wire logic        run_stop_in,
  input wire logic [3:0]  axis_cmd_ready_in,
  input wire logic [3:0]  axis_pos_valid_out,
  input wire logic [3:0]  axis_speed_valid_out,
  input wire logic [15:0] axis_cmd_data_out,
  input wire logic        run_busy_out,
  input wire logic        run_fault_out,
  input wire logic [7:0]  step_ptr_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire logic [3:0] vld = axis_pos_valid_out | axis_speed_valid_out;
  wire logic       go = !run_stop_in;
  // ------
  // Properties
  // ------
  sequence s_pos_take;
    |(axis_pos_valid_out & axis_cmd_ready_in) && go;
  endsequence
  sequence s_spd_take;
    |(axis_speed_valid_out & axis_cmd_ready_in) && go;
  endsequence
  sequence s_step_on;
    vld == 4'h0 && step_ptr_out == $past(step_ptr_out) + 8'h01;
  endsequence
  property p_pos_adv; s_pos_take |=> s_step_on; endproperty
  property p_spd_adv; s_spd_take |=> s_step_on; endproperty
  property p_hold;
    vld != 4'h0 && (vld & axis_cmd_ready_in) == 4'h0 && go
      |=> $stable(vld) && $stable(axis_cmd_data_out);
  endproperty
  property p_onehot;
    $onehot0({axis_pos_valid_out, axis_speed_valid_out});
  endproperty
  property p_busy; vld != 4'h0 |-> run_busy_out && !run_fault_out; endproperty
  property p_start;
    !run_busy_out && run_start_in && go
      |=> run_busy_out && step_ptr_out == $past(run_start_step_in);
  endproperty
  property p_stop; run_stop_in |=> !run_busy_out && vld == 4'h0; endproperty
  property p_fault;
    run_fault_out && !run_start_in && go
      |=> run_fault_out && $stable(step_ptr_out);
  endproperty
  a_pos_adv: assert property (p_pos_adv)
    else $error("no advance after move");
  a_spd_adv: assert property (p_spd_adv)
    else $error("no advance after speed");
  a_hold: assert property (p_hold)
    else $error("command dropped early");
  a_onehot: assert property (p_onehot)
    else $error("two commands at once");
  a_busy: assert property (p_busy)
    else $error("command while not running");
  a_start: assert property (p_start)
    else $error("start not taken");
  a_stop: assert property (p_stop)
    else $error("stop not taken");
  a_fault: assert property (p_fault)
    else $error("fault not held");
endmodule

bind wsse_executor wsse_asserts u_asserts (
  .clk_sys_in, .rst_in, .run_start_in, .run_start_step_in, .run_stop_in,
  .axis_cmd_ready_in, .axis_pos_valid_out, .axis_speed_valid_out,
  .axis_cmd_data_out, .run_busy_out, .run_fault_out, .step_ptr_out
);

/* tb/wsse_drive_model.sv */
`timescale 1ns/100ps
module wsse_drive_model #(
  parameter int MOVE_CYC = 40
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       slow_in,
  input  wire logic       weld_finish_in,
  input  wire logic [3:0] pos_valid_in,
  input  wire logic [3:0] speed_valid_in,
  output logic      [3:0] cmd_ready_out,
  output logic      [3:0] move_done_out,
  output logic            weld_done_out
);
  logic [2:0] wait_r;
  int         tmr [4];
  wire logic [3:0] vld = pos_valid_in | speed_valid_in;
  wire logic [3:0] take = vld & cmd_ready_out;
  // Slow drives hold off ready for a few cycles
  wire logic       ok = !slow_in || wait_r >= 3'h3;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_ready_out <= 4'h0;
      move_done_out <= 4'hF;
      weld_done_out <= 1'b0;
      wait_r <= 3'h0;
      for (int i = 0; i < 4; i++) tmr[i] <= 0;
    end else begin
      cmd_ready_out <= vld & ~take & {4{ok}};
      wait_r <= (vld != 4'h0 && take == 4'h0) ? wait_r + 3'h1 : 3'h0;
      weld_done_out <= weld_finish_in;
      for (int i = 0; i < 4; i++) begin
        if (take[i] && pos_valid_in[i]) begin
          move_done_out[i] <= 1'b0;
          tmr[i] <= MOVE_CYC;
        end else if (tmr[i] == 1) begin
          move_done_out[i] <= 1'b1;
          tmr[i] <= 0;
        end else if (tmr[i] != 0) begin
          tmr[i] <= tmr[i] - 1;
        end
      end
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        prog_wr_en_in = 1'b0;
  logic [7:0]  prog_wr_step_in = 8'h00;
  logic [7:0]  prog_wr_opcode_in = 8'h00;
  logic [15:0] prog_wr_value_in = 16'h0000;
  logic        run_start_in = 1'b0;
  logic [7:0]  run_start_step_in = 8'h00;
  logic        run_stop_in = 1'b0;
  logic        arc_sample_valid_in = 1'b0;
  logic [15:0] arc_voltage_in = 16'h0000;
  logic [15:0] arc_current_in = 16'h0000;
  logic [15:0] arc_on_voltage_threshold_in = 16'h1000;
  logic [15:0] arc_on_current_threshold_in = 16'h1000;
  logic        slow = 1'b0;
  logic        hot;
  logic [7:0]  last_ptr = 8'h00;
  wire  logic  weld_cycle_done_in, run_busy_out, run_fault_out;
  wire  logic  arc_present_out;
  wire  logic [3:0]  axis_move_done_in, axis_cmd_ready_in;
  wire  logic [3:0]  axis_pos_valid_out, axis_speed_valid_out;
  wire  logic [15:0] axis_cmd_data_out;
  wire  logic [7:0]  step_ptr_out;
  wire  logic  weld_fin = step_ptr_out >= 8'h78;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;
  int          seed = 14;
  int          want_ptr;
  int          want_cmd;
  int          op [256];
  int          val [256];
  int          exp_ptr [$];
  int          exp_cmd [$];
  int          tbl [12][3] = '{'{8, 22, 16'h2800}, '{40, 11, 16'h323C},
    '{50, 12, 16'h4600}, '{70, 13, 16'h005A}, '{90, 23, 16'h0064},
    '{100, 25, 16'h0000}, '{101, 24, 16'h0778}, '{120, 12, 16'h0000},
    '{121, 11, 16'h0000}, '{122, 11, 16'h0982}, '{130, 12, 16'h098C},
    '{140, 0, 16'h0000}};

  wsse_executor #(.ARC_QUAL_SAMPLES(1)) dut (
    .clk_sys_in, .rst_in, .prog_wr_en_in, .prog_wr_step_in,
    .prog_wr_opcode_in, .prog_wr_value_in, .run_start_in,
    .run_start_step_in, .run_stop_in, .arc_sample_valid_in,
    .arc_voltage_in, .arc_current_in, .arc_on_voltage_threshold_in,
    .arc_on_current_threshold_in, .weld_cycle_done_in,
    .axis_move_done_in, .axis_cmd_ready_in, .axis_pos_valid_out,
    .axis_speed_valid_out, .axis_cmd_data_out, .run_busy_out,
    .run_fault_out, .step_ptr_out, .arc_present_out);
  wsse_drive_model u_far (.clk_sys_in, .rst_in, .slow_in(slow),
    .weld_finish_in(weld_fin), .pos_valid_in(axis_pos_valid_out),
    .speed_valid_in(axis_speed_valid_out),
    .cmd_ready_out(axis_cmd_ready_in), .move_done_out(axis_move_done_in),
    .weld_done_out(weld_cycle_done_in));

  always #12.5 clk_sys_in = ~clk_sys_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------
  // Reference walk of the program
  // ------
  task automatic build;
    int p, n, o, hi, lo, k;
    bit c, a, w;
    bit [3:0] mv;
    {a, w, mv, p} = 0;
    exp_ptr.delete();
    exp_cmd.delete();
    if (step_ptr_out !== 8'h00) exp_ptr.push_back(0);
    while (1) begin
      o = op[p];
      hi = val[p] >> 8;
      lo = val[p] & 255;
      if (o >= 14 && o <= 21) begin
        k = (o >= 18 ? 1 << 20 : 0) | (1 << ((o - 14) % 4 + 16));
        exp_cmd.push_back(k | val[p]);
        if (o < 18) mv[o - 14] = 1'b1;
        n = p + 1;
      end else if (o == 13) n = lo;
      else if (o == 11 || o == 12 || (o >= 22 && o <= 25)) begin
        c = (o == 11) ? a : (o == 12) ? w : !mv[o - 22];
        if (!c && hi == 0) begin
          // A wait ends on its event; all moves share one duration
          c = 1'b1;
          a = a | (o == 11);
          w = w | (o == 12);
          if (o > 21) mv = 4'h0;
        end
        n = c ? (lo != 0 ? lo : p + 1) : hi;
      end else break;
      p = n & 255;
      exp_ptr.push_back(p);
    end
  endtask

  task automatic run_pass;
    for (int i = 0; i < 256; i++) begin
      val[i] = i < 8 ? $random(seed) & 16'hFFFF : 0;
      op[i] = i >= 8 ? 0 : i < 4 ? 18 + i : 10 + i;
    end
    foreach (tbl[j]) op[tbl[j][0]] = tbl[j][1];
    foreach (tbl[j]) val[tbl[j][0]] = tbl[j][2];
    val[70] = val[70] | (($random(seed) & 255) << 8);
    build;
    for (int i = 0; i < 150; i++) begin
      @(negedge clk_sys_in);
      prog_wr_en_in = 1'b1;
      prog_wr_step_in = 8'(i);
      prog_wr_opcode_in = 8'(op[i]);
      prog_wr_value_in = 16'(val[i]);
    end
    @(negedge clk_sys_in);
    prog_wr_en_in = 1'b0;
    run_start_in = 1'b1;
    @(negedge clk_sys_in);
    run_start_in = 1'b0;
    while (run_fault_out !== 1'b1) @(negedge clk_sys_in);
    check(step_ptr_out, 8'h8C);
    check(arc_present_out, 1'b1);
    check(exp_ptr.size(), 0);
    check(exp_cmd.size(), 0);
  endtask
  // ------
  // Monitor and drive
  // ------
  always @(negedge clk_sys_in) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      finish_test;
    end
  end

  always @(negedge clk_sys_in) begin
    hot = step_ptr_out >= 8'h79;
    arc_sample_valid_in = 1'b1;
    arc_voltage_in = {3'h0, hot, 12'($random(seed))};
    arc_current_in = {3'h0, hot, 12'($random(seed))};
    if (run_busy_out === 1'b1 && step_ptr_out !== last_ptr) begin
      want_ptr = exp_ptr.size() ? exp_ptr.pop_front() : 999;
      check(step_ptr_out, want_ptr);
    end
    // Step 50 is only reached with the arc still absent
    if (step_ptr_out === 8'h32)
      check(arc_present_out, 1'b0);
    last_ptr = step_ptr_out;
    if (|(axis_cmd_ready_in &
          (axis_pos_valid_out | axis_speed_valid_out))) begin
      want_cmd = exp_cmd.size() ? exp_cmd.pop_front() : 0;
      check({|axis_speed_valid_out, axis_pos_valid_out | axis_speed_valid_out,
        axis_cmd_data_out}, want_cmd);
    end
  end

  initial begin
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    run_pass;
    slow = 1'b1;
    run_pass;
    @(negedge clk_sys_in);
    run_stop_in = 1'b1;
    @(negedge clk_sys_in);
    run_stop_in = 1'b0;
    check(run_fault_out, 1'b0);
    check(run_busy_out, 1'b0);
    finish_test;
  end
endmodule
